// File: srfm_axil.sv
// Purpose: AXI4-Lite slave front end giving simple register strobes
// Assumes: One write and one read outstanding at most
// Notes:   Write address and data taken in either order
`timescale 1ns/10ps
module srfm_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic             rd_stb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  import srfm_pkg::*;
  logic        aw_reg, aw_next, w_reg, w_next, b_reg, b_next;
  logic        r_reg, r_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;

  assign s_awready = !aw_reg && !b_reg;
  assign s_wready  = !w_reg && !b_reg;
  assign s_arready = !r_reg;
  assign wr_stb  = aw_reg && w_reg && !b_reg;
  assign wr_addr = awa_reg;
  assign wr_data = wd_reg;
  assign wr_strb = ws_reg;
  assign rd_stb  = s_arvalid && s_arready;
  assign rd_addr = s_araddr;
  assign s_bvalid = b_reg;
  assign s_bresp  = br_reg;
  assign s_rvalid = r_reg;
  assign s_rdata  = rd_reg;
  assign s_rresp  = rr_reg;

  // Channel capture and response state
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; b_next = b_reg; r_next = r_reg;
    awa_next = awa_reg; wd_next = wd_reg; ws_next = ws_reg;
    br_next = br_reg; rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_awvalid && s_awready) begin
      aw_next = 1'b1; awa_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_next = 1'b1; wd_next = s_wdata; ws_next = s_wstrb;
    end
    if (wr_stb) begin
      b_next = 1'b1; aw_next = 1'b0; w_next = 1'b0;
      br_next = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (b_reg && s_bready) b_next = 1'b0;
    if (rd_stb) begin
      r_next = 1'b1; rd_next = rd_data;
      rr_next = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (r_reg && s_rready) begin
      r_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; r_reg <= 1'b0;
      awa_reg <= 8'h00; wd_reg <= 32'h0; ws_reg <= 4'h0;
      br_reg <= 2'b00; rd_reg <= 32'h0;
      rr_reg <= 2'b00;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next;
      r_reg <= r_next; awa_reg <= awa_next; wd_reg <= wd_next;
      ws_reg <= ws_next; br_reg <= br_next;
      rd_reg <= rd_next; rr_reg <= rr_next;
    end
  end
endmodule : srfm_axil

// File: srfm_host_model.sv
// Purpose: Host model on the AXI4-Lite register port
// Assumes: Driven just after rising aclk edges, one transfer at a time
// Notes:   Released payload shows the inverse of the last value
`timescale 1ns/10ps
module srfm_host_model #(
  parameter int unsigned SETTLE_CYC =
    srfm_pkg::SETTLE_US * (srfm_pkg::CLK_HZ / 1000000)
) (
  input  wire logic        aclk,
  output logic [7:0]       s_awaddr,
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  output logic [7:0]       s_araddr,
  output logic             s_arvalid,
  input  wire logic        s_arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  s_rresp,
  input  wire logic        s_rvalid,
  output logic             s_rready
);
  import srfm_pkg::*;
  // Idle bus from time zero
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_wstrb} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
  end
  // Write; each channel dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    s_awaddr  <= a;
    s_awvalid <= 1'b1;
    s_wdata   <= d;
    s_wstrb   <= 4'hf;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
        s_awaddr  <= ~a;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
        s_wdata  <= ~d;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  // Read; data taken at the edge that shows rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_araddr  <= ~a;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // One code at a time, avoids false rail faults
  task automatic step_level(input logic up, output logic [1:0] r);
    logic [31:0] cur;
    rd(OFS_LEVEL, cur, r);
    wr(OFS_LEVEL, up ? cur + 32'h1 : cur - 32'h1, r);
    repeat (SETTLE_CYC) @(posedge aclk);
  endtask : step_level
  // Fault reaction is the host's choice: rail off
  task automatic shut_rail(output logic [1:0] r);
    wr(OFS_CTRL, 32'h0, r);
  endtask : shut_rail
endmodule : srfm_host_model

// File: srfm_octo.sv
// Purpose: Overcurrent persistence timer for the step-down rail
// Assumes: limit_active is synchronous to aclk
// Notes:   Pulses expired once per unbroken limiting run
`timescale 1ns/10ps
module srfm_octo #(
  parameter int unsigned TIMEOUT_CYC = srfm_pkg::OC_TIMEOUT_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic limit_active,
  output logic      expired
);
  import srfm_pkg::*;
  logic [31:0] cnt_reg, cnt_next;
  logic        fired_reg, fired_next;

  // Count unbroken limiting; any break restarts the run
  always_comb begin
    cnt_next   = cnt_reg;
    fired_next = fired_reg;
    if (!limit_active) begin
      cnt_next   = 32'h0;
      fired_next = 1'b0;
    end else if (cnt_reg < TIMEOUT_CYC) begin
      cnt_next = cnt_reg + 32'h1;
    end else begin
      fired_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg   <= 32'h0;
      fired_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      fired_reg <= fired_next;
    end
  end

  // One pulse when the run reaches the timeout
  assign expired = limit_active && !fired_reg && (cnt_reg >= TIMEOUT_CYC);
endmodule : srfm_octo

// File: srfm_pkg.sv
// Purpose: Shared constants for the step-down rail fault monitor
// Assumes: 20 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package srfm_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned OC_TIMEOUT_US = 100;
  localparam int unsigned OC_TIMEOUT_CYC =
    (OC_TIMEOUT_US * (CLK_HZ / 1000000));
  localparam int unsigned SETTLE_US     = 50;
  localparam int unsigned STEP_MV       = 50;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR  = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_LIVE   = 8'h0c;
  localparam logic [7:0] OFS_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_LEVEL2 = 8'h14;
  localparam logic [7:0] OFS_CTRL   = 8'h18;

  // Event bit positions in status, clear and enable
  localparam int unsigned EV_OCTO = 0;
  localparam int unsigned EV_OTW  = 1;
  localparam int unsigned EV_TSD  = 2;
  localparam int unsigned EV_N    = 3;

  // Live register bit positions
  localparam int unsigned LV_OTW  = 0;
  localparam int unsigned LV_USED = 1;
  localparam int unsigned LV_CL   = 2;
  localparam int unsigned LV_ON   = 3;

  // Control register bit positions
  localparam int unsigned CT_EN   = 0;
  localparam int unsigned CT_SYNC = 1;

  // Output level code
  localparam int unsigned LVL_W   = 4;
  localparam logic [3:0] LVL_RST  = 4'h7;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : srfm_pkg

// File: srfm_tb_top.sv
// Purpose: Self-checking bench of the step-down rail monitor
// Assumes: Short overcurrent timeout and settle time
// Notes:   Comparators driven as plain levels
`timescale 1ns/10ps
module srfm_tb_top;
  import srfm_pkg::*;
  localparam int unsigned TO_CYC = 20;
  localparam logic [31:0] LIVE_RUN = (32'h1 << LV_USED) | (32'h1 << LV_ON);
  localparam logic [31:0] OT_BOTH = (32'h1 << EV_OTW) | (32'h1 << EV_TSD);
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rdv;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic        active_state, start_request, rail_input_detect, period_start;
  logic        peak_current_hit, low_side_overcurrent, overtemp_warn_cmp;
  logic        overtemp_shutdown_cmp, sync_clk_internal, sync_clk_external;
  logic        high_side_on, converter_enabled, switch_clock, irq;
  logic        thermal_shutdown_event;
  logic [LVL_W-1:0] output_level_code;
  int          miscompares, num_checks, cyc;
  srfm_top #(.TIMEOUT_CYC(TO_CYC)) i_dut (.*);
  srfm_host_model #(.SETTLE_CYC(10)) i_host (.*);
  // Bench clock; offsets keep sync clock edges off both aclk edges
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    sync_clk_internal = 1'b0;
    #7;
    forever #20 sync_clk_internal = ~sync_clk_internal;
  end
  initial begin
    sync_clk_external = 1'b1;
    #11;
    forever #30 sync_clk_external = ~sync_clk_external;
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
    i_host.rd(a, rdv, rsp);
    chk(nm, rdv, e);
  endtask : rchk
  // One switching period start, ends mid-cycle
  task automatic pulse();
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
    @(negedge aclk);
  endtask : pulse
  task automatic wait_en(input logic v);
    for (int i = 0; i < 50; i++)
      if (converter_enabled !== v)
        @(posedge aclk);
  endtask : wait_en
  task automatic t_regs();
    rchk(OFS_STATUS, 32'h0, "st_rst");
    rchk(OFS_LEVEL, 32'(LVL_RST), "lvl_rst");
    i_host.rd(8'h40, rdv, rsp);
    chk("bad_rsp", 32'(rsp), 32'(RESP_SLVERR));
    chk("bad_dat", rdv, 32'h0);
    i_host.wr(8'h40, 32'h0, rsp);
    chk("bad_wr", 32'(rsp), 32'(RESP_SLVERR));
  endtask : t_regs
  // Strapped input keeps the rail off, then a live input starts it
  task automatic t_detect();
    start_request <= 1'b1;
    wait_en(1'b1);
    chk("unused", 32'(converter_enabled), 32'h0);
    rchk(OFS_LIVE, 32'h0, "live_un");
    rail_input_detect <= 1'b1;
    wait_en(1'b1);
    chk("used", 32'(converter_enabled), 32'h1);
    rchk(OFS_LIVE, LIVE_RUN, "live_use");
  endtask : t_detect
  task automatic t_hs();
    @(posedge aclk);
    pulse();
    chk("hs_on", 32'(high_side_on), 32'h1);
    @(posedge aclk);
    peak_current_hit <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("hs_cut", 32'(high_side_on), 32'h0);
    @(posedge aclk);
    peak_current_hit     <= 1'b0;
    low_side_overcurrent <= 1'b1;
    pulse();
    repeat (3) begin
      chk("hs_skip", 32'(high_side_on), 32'h0);
      @(negedge aclk);
    end
    @(posedge aclk);
    low_side_overcurrent <= 1'b0;
    pulse();
    chk("hs_back", 32'(high_side_on), 32'h1);
    // A period with no limiting ends the run before the timeout test
    @(posedge aclk);
    pulse();
  endtask : t_hs
  // Unbroken skipping trips the timeout; flag stays until cleared
  task automatic t_octo();
    i_host.wr(OFS_ENABLE, 32'h7, rsp);
    chk("wr_ok", 32'(rsp), 32'(RESP_OKAY));
    low_side_overcurrent <= 1'b1;
    for (int i = 0; i < TO_CYC; i++) begin
      if (i == 10)
        chk("oc_early", 32'(irq), 32'h0);
      pulse();
      @(posedge aclk);
    end
    low_side_overcurrent <= 1'b0;
    pulse();
    chk("oc_irq", 32'(irq), 32'h1);
    chk("oc_run", 32'(converter_enabled), 32'h1);
    rchk(OFS_LIVE, LIVE_RUN | (32'h1 << LV_CL), "live_cl");
    // Unlimited period closes the run so later live reads see no limiting
    pulse();
    rchk(OFS_STATUS, 32'h1 << EV_OCTO, "oc_st");
    i_host.wr(OFS_ENABLE, 32'h0, rsp);
    chk("irq_msk", 32'(irq), 32'h0);
    i_host.wr(OFS_ENABLE, 32'h7, rsp);
    chk("irq_en", 32'(irq), 32'h1);
    i_host.wr(OFS_CLEAR, 32'h1 << EV_OCTO, rsp);
    rchk(OFS_STATUS, 32'h0, "oc_clr");
    chk("irq_clr", 32'(irq), 32'h0);
  endtask : t_octo
  task automatic t_temp();
    @(posedge aclk);
    overtemp_warn_cmp <= 1'b1;
    rchk(OFS_LIVE, LIVE_RUN | (32'h1 << LV_OTW), "live_w");
    rchk(OFS_STATUS, 32'h1 << EV_OTW, "st_w");
    chk("irq_w", 32'(irq), 32'h1);
    overtemp_warn_cmp <= 1'b0;
    rchk(OFS_LIVE, LIVE_RUN, "live_wo");
    rchk(OFS_STATUS, 32'h1 << EV_OTW, "st_wh");
    overtemp_shutdown_cmp <= 1'b1;
    @(negedge aclk);
    chk("tsd_ev", 32'(thermal_shutdown_event), 32'h1);
    @(negedge aclk);
    chk("tsd_off", 32'({converter_enabled, high_side_on}), 32'h0);
    rchk(OFS_STATUS, OT_BOTH, "st_tsd");
    overtemp_shutdown_cmp <= 1'b0;
    i_host.shut_rail(rsp);
    i_host.wr(OFS_CTRL, 32'h1 << CT_EN, rsp);
    wait_en(1'b1);
    chk("restart", 32'(converter_enabled), 32'h1);
    rchk(OFS_STATUS, OT_BOTH, "st_act");
    i_host.wr(OFS_CLEAR, 32'h7, rsp);
    rchk(OFS_STATUS, 32'h0, "st_clr");
  endtask : t_temp
  // Single steps apply; a write outside the active state is ignored
  task automatic t_level();
    i_host.step_level(1'b1, rsp);
    chk("lv_up", 32'(output_level_code), 32'(LVL_RST) + 32'h1);
    chk("lv_mv", 32'(output_level_code - LVL_RST) * STEP_MV, 32'd50);
    i_host.step_level(1'b0, rsp);
    chk("lv_dn", 32'(output_level_code), 32'(LVL_RST));
    active_state <= 1'b0;
    i_host.wr(OFS_LEVEL, 32'(LVL_RST) + 32'h1, rsp);
    chk("lv_idle", 32'(output_level_code), 32'(LVL_RST));
    active_state <= 1'b1;
    i_host.wr(OFS_LEVEL2, 32'(LVL_RST) - 32'h1, rsp);
    rchk(OFS_LEVEL2, 32'(LVL_RST) - 32'h1, "lv2");
  endtask : t_level
  task automatic t_sync();
    logic want;
    for (int i = 0; i < 6; i++) begin
      if (i == 3)
        i_host.wr(OFS_CTRL, (32'h1 << CT_EN) | (32'h1 << CT_SYNC), rsp);
      @(negedge aclk);
      want = (i < 3) ? sync_clk_internal : sync_clk_external;
      chk("sw_clk", 32'(switch_clock), 32'(want));
    end
  endtask : t_sync
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {period_start, peak_current_hit, low_side_overcurrent} = 3'h0;
    {overtemp_warn_cmp, overtemp_shutdown_cmp, rail_input_detect} = 3'h0;
    active_state  = 1'b1;
    start_request = 1'b0;
    repeat (6) @(posedge aclk);
    chk("rst_irq", 32'(irq), 32'h0);
    chk("rst_lvl", 32'(output_level_code), 32'(LVL_RST));
    aresetn <= 1'b1;
    t_regs();
    t_detect();
    t_hs();
    t_octo();
    t_temp();
    t_level();
    t_sync();
    final_report();
  end
endmodule : srfm_tb_top

// File: srfm_top.sv
// Purpose: Supervision and control logic of the second step-down rail
// Assumes: Comparator inputs synchronous to aclk, 20 MHz clock
// Notes:   Analog regulation stays outside; this drives gates and target
`timescale 1ns/10ps
module srfm_top #(
  parameter int unsigned TIMEOUT_CYC = srfm_pkg::OC_TIMEOUT_CYC,
  parameter int unsigned LVL_W       = srfm_pkg::LVL_W
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        active_state,
  input  wire logic        start_request,
  input  wire logic        rail_input_detect,
  input  wire logic        period_start,
  input  wire logic        peak_current_hit,
  input  wire logic        low_side_overcurrent,
  input  wire logic        overtemp_warn_cmp,
  input  wire logic        overtemp_shutdown_cmp,
  input  wire logic        sync_clk_internal,
  input  wire logic        sync_clk_external,
  output logic             high_side_on,
  output logic             converter_enabled,
  output logic             switch_clock,
  output logic [LVL_W-1:0] output_level_code,
  output logic             thermal_shutdown_event,
  output logic             irq
);
  import srfm_pkg::*;

  typedef enum logic [1:0] {ST_OFF, ST_DETECT, ST_RUN, ST_TRIPPED}
    srfm_state_t;

  logic              wr_stb, rd_stb, wr_err, rd_err;
  logic [7:0]        wr_addr, rd_addr;
  logic [31:0]       wr_data, rd_data;
  logic [3:0]        wr_strb;
  logic              oc_expired;

  srfm_state_t       st_reg, st_next;
  logic              hs_reg, hs_next;
  logic              skip_reg, skip_next;
  logic              cl_reg, cl_next;
  logic              used_reg, used_next;
  logic              otw_d_reg, otw_d_next;
  logic              tsd_d_reg, tsd_d_next;
  logic              sync_reg, sync_next;
  logic              en_ctl_reg, en_ctl_next;
  logic [EV_N-1:0]   stat_reg, stat_next;
  logic [EV_N-1:0]   ien_reg, ien_next;
  logic [LVL_W-1:0]  lvl_reg, lvl_next;
  logic [LVL_W-1:0]  lvl2_reg, lvl2_next;
  logic [EV_N-1:0]   ev_set, ev_clr;
  logic              tsd_rise;

  srfm_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  // Limiting counts as active while skipping or cut by peak current
  srfm_octo #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_octo (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .limit_active (cl_reg),
    .expired      (oc_expired)
  );

  assign tsd_rise = overtemp_shutdown_cmp && !tsd_d_reg;

  // Events set, software clears; set wins over clear
  always_comb begin
    ev_set          = '0;
    ev_set[EV_OCTO] = oc_expired;
    ev_set[EV_OTW]  = overtemp_warn_cmp && !otw_d_reg;
    ev_set[EV_TSD]  = tsd_rise;
    ev_clr = '0;
    if (wr_stb && wr_addr == OFS_CLEAR && wr_strb[0])
      ev_clr = wr_data[EV_N-1:0];
    stat_next = (stat_reg & ~ev_clr) | ev_set;
  end

  // Rail sequencing: detect before start, trip on overtemperature
  always_comb begin
    st_next   = st_reg;
    used_next = used_reg;
    unique case (st_reg)
      ST_OFF: begin
        if (start_request && en_ctl_reg) st_next = ST_DETECT;
      end
      ST_DETECT: begin
        used_next = rail_input_detect;
        st_next   = rail_input_detect ? ST_RUN : ST_OFF;
      end
      ST_RUN: begin
        if (!en_ctl_reg) st_next = ST_OFF;
      end
      ST_TRIPPED: begin
        if (!overtemp_shutdown_cmp && !en_ctl_reg) st_next = ST_OFF;
      end
    endcase
    if (overtemp_shutdown_cmp && st_reg != ST_OFF)
      st_next = ST_TRIPPED;
  end

  // High-side gate per switching period with blanking
  always_comb begin
    hs_next   = hs_reg;
    skip_next = skip_reg;
    cl_next   = cl_reg;
    if (st_reg != ST_RUN || overtemp_shutdown_cmp) begin
      hs_next   = 1'b0;
      skip_next = 1'b0;
      cl_next   = 1'b0;
    end else if (period_start) begin
      skip_next = low_side_overcurrent;
      hs_next   = !low_side_overcurrent;
      cl_next   = low_side_overcurrent || (cl_reg && (skip_reg || !hs_reg));
    end else if (peak_current_hit && hs_reg) begin
      hs_next = 1'b0;
      cl_next = 1'b1;
    end
  end

  // Host registers: enables, control and level codes
  always_comb begin
    ien_next    = ien_reg;
    en_ctl_next = en_ctl_reg;
    sync_next   = sync_reg;
    lvl_next    = lvl_reg;
    lvl2_next   = lvl2_reg;
    wr_err      = 1'b0;
    if (wr_stb && wr_strb[0]) begin
      unique case (wr_addr)
        OFS_ENABLE: ien_next = wr_data[EV_N-1:0];
        OFS_CTRL: begin
          en_ctl_next = wr_data[CT_EN];
          sync_next   = wr_data[CT_SYNC];
        end
        OFS_LEVEL:  if (active_state) lvl_next  = wr_data[LVL_W-1:0];
        OFS_LEVEL2: if (active_state) lvl2_next = wr_data[LVL_W-1:0];
        OFS_CLEAR, OFS_STATUS, OFS_LIVE: ;
        default: wr_err = 1'b1;
      endcase
    end
  end

  // Read multiplexer; unmapped addresses answer with an error
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    unique case (rd_addr)
      OFS_STATUS: rd_data[EV_N-1:0] = stat_reg;
      OFS_CLEAR:  rd_data = 32'h0;
      OFS_ENABLE: rd_data[EV_N-1:0] = ien_reg;
      OFS_LIVE: begin
        rd_data[LV_OTW]  = overtemp_warn_cmp;
        rd_data[LV_USED] = used_reg;
        rd_data[LV_CL]   = cl_reg;
        rd_data[LV_ON]   = (st_reg == ST_RUN);
      end
      OFS_LEVEL:  rd_data[LVL_W-1:0] = lvl_reg;
      OFS_LEVEL2: rd_data[LVL_W-1:0] = lvl2_reg;
      OFS_CTRL: begin
        rd_data[CT_EN]   = en_ctl_reg;
        rd_data[CT_SYNC] = sync_reg;
      end
      default: rd_err = 1'b1;
    endcase
  end

  assign otw_d_next = overtemp_warn_cmp;
  assign tsd_d_next = overtemp_shutdown_cmp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg     <= ST_OFF;
      hs_reg     <= 1'b0;
      skip_reg   <= 1'b0;
      cl_reg     <= 1'b0;
      used_reg   <= 1'b0;
      otw_d_reg  <= 1'b0;
      tsd_d_reg  <= 1'b0;
      sync_reg   <= 1'b0;
      en_ctl_reg <= 1'b1;
      stat_reg   <= '0;
      ien_reg    <= '0;
      lvl_reg    <= LVL_RST[LVL_W-1:0];
      lvl2_reg   <= LVL_RST[LVL_W-1:0];
    end else begin
      st_reg     <= st_next;
      hs_reg     <= hs_next;
      skip_reg   <= skip_next;
      cl_reg     <= cl_next;
      used_reg   <= used_next;
      otw_d_reg  <= otw_d_next;
      tsd_d_reg  <= tsd_d_next;
      sync_reg   <= sync_next;
      en_ctl_reg <= en_ctl_next;
      stat_reg   <= stat_next;
      ien_reg    <= ien_next;
      lvl_reg    <= lvl_next;
      lvl2_reg   <= lvl2_next;
    end
  end

  // Outputs; sync select is a plain mux, glitch on change is accepted
  assign high_side_on           = hs_reg;
  assign converter_enabled      = (st_reg == ST_RUN);
  assign output_level_code      = lvl_reg;
  assign switch_clock           = sync_reg ? sync_clk_external
                                           : sync_clk_internal;
  assign thermal_shutdown_event = tsd_rise;
  assign irq                    = |(stat_reg & ien_reg);

  // Checks
  property p_peak_off;
    @(posedge aclk) disable iff (!aresetn)
      (hs_reg && peak_current_hit && !period_start) |=> !hs_reg;
  endproperty
  a_peak_off: assert property (p_peak_off)
    else $error("high side not cut on peak current");

  sequence s_blank;
    (period_start && low_side_overcurrent && st_reg == ST_RUN);
  endsequence
  property p_blank;
    @(posedge aclk) disable iff (!aresetn)
      s_blank |=> (!hs_reg throughout (!period_start)[*1]);
  endproperty
  a_blank: assert property (p_blank)
    else $error("high side on in blanked period");

  property p_octo;
    @(posedge aclk) disable iff (!aresetn)
      oc_expired |=> stat_reg[EV_OCTO];
  endproperty
  a_octo: assert property (p_octo)
    else $error("timeout flag not set");

  property p_otw;
    @(posedge aclk) disable iff (!aresetn)
      $rose(overtemp_warn_cmp) |=> stat_reg[EV_OTW];
  endproperty
  a_otw: assert property (p_otw)
    else $error("warning flag not latched");

  property p_tsd;
    @(posedge aclk) disable iff (!aresetn)
      overtemp_shutdown_cmp |=> !converter_enabled && !high_side_on;
  endproperty
  a_tsd: assert property (p_tsd)
    else $error("converter not disabled on shutdown");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      (stat_reg[EV_TSD] && !(wr_stb && wr_addr == OFS_CLEAR))
        |=> stat_reg[EV_TSD];
  endproperty
  a_hold: assert property (p_hold)
    else $error("shutdown flag lost without clear");

  property p_lvl;
    @(posedge aclk) disable iff (!aresetn)
      (wr_stb && wr_strb[0] && wr_addr == OFS_LEVEL && active_state)
        |=> output_level_code == $past(wr_data[LVL_W-1:0]);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("level write not applied");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      irq == |(stat_reg & ien_reg);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt mismatch");
endmodule : srfm_top
